//--- ecid_pkg.sv
// Shared constants and types for the extended instruction decode core.
// Assumes one instruction cycle per aclk edge and an AXI4-Lite host.
`default_nettype none
package ecid_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam int BANK_W = 4;
  localparam int UPPER_W = 5;
  localparam int AXIL_AW = 8;
  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [5:0] OP_XOR_FILE = 6'h06;
  localparam logic [7:0] OP_PTR_ADD = 8'he8;
  localparam logic [7:0] OP_PTR_SUB = 8'he9;
  localparam logic [7:0] OP_PUSH_LIT = 8'hea;
  localparam logic [7:0] OP_MOVE_IDX = 8'heb;
  localparam logic [15:0] OP_CALL_ACC = 16'h0014;
  localparam logic [3:0] WORD2_PREFIX = 4'hf;
  localparam logic [1:0] PTR_FRAME = 2'h3;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [3:0] PAGE_LOW = 4'h0;
  localparam logic [3:0] PAGE_SFR = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  ////////////////////////////////////////////////////////////////////////////
  // Status bits
  localparam int STAT_Z_BIT = 2;
  localparam int STAT_N_BIT = 4;
  localparam int STAT_W = 5;
  localparam int CTRL_EXT_BIT = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [AXIL_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXIL_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AXIL_AW-1:0] REG_ACCUM = 8'h08;
  localparam logic [AXIL_AW-1:0] REG_BANK = 8'h0c;
  localparam logic [AXIL_AW-1:0] REG_PCLAT = 8'h10;
  localparam logic [AXIL_AW-1:0] REG_PC = 8'h14;
  localparam logic [AXIL_AW-1:0] REG_PTR0 = 8'h18;
  localparam logic [AXIL_AW-1:0] REG_PTR1 = 8'h1c;
  localparam logic [AXIL_AW-1:0] REG_PTR2 = 8'h20;
  localparam logic [AXIL_AW-1:0] REG_MADDR = 8'h24;
  localparam logic [AXIL_AW-1:0] REG_MDATA = 8'h28;
  localparam logic [AXIL_AW-1:0] REG_RSTACK = 8'h2c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {ST_RUN, ST_NOP2, ST_WORD2} ecid_state_t;
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ecid_mwr_t;
  typedef struct packed {
    logic en;
    logic [AXIL_AW-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ecid_bwr_t;
  // Matches the high opcode byte of an instruction word
  function automatic logic ecid_op_hi(input logic [15:0] w, input logic [7:0] op);
    return w[15:8] == op;
  endfunction
endpackage
`default_nettype wire

//--- ecid_addr.sv
// Effective file address for byte-oriented instructions.
// Assumes the frame pointer is stable during the instruction cycle.
`default_nettype none
module ecid_addr
  import ecid_pkg::*;
(
  input wire logic [7:0] file_addr,
  input wire logic access_sel,
  input wire logic [BANK_W-1:0] bank,
  input wire logic ext_en,
  input wire logic [ADDR_W-1:0] frame_ptr,
  output logic [ADDR_W-1:0] eff_addr,
  output logic indexed
);
  ////////////////////////////////////////////////////////////////////////////
  // Access bank split, banked and indexed forms
  logic low_part;
  logic [ADDR_W-1:0] access_addr;
  logic [ADDR_W-1:0] frame_addr;
  assign low_part = file_addr <= ACCESS_LIMIT;
  assign access_addr = low_part ? {PAGE_LOW, file_addr} : {PAGE_SFR, file_addr};
  assign frame_addr = ADDR_W'(frame_ptr + {PAGE_LOW, file_addr});
  assign indexed = ext_en & ~access_sel & low_part;
  assign eff_addr = indexed ? frame_addr : (access_sel ? {bank, file_addr} : access_addr);
endmodule
`default_nettype wire

//--- ecid_axil.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the owner answers rd_data/rd_err combinationally from rd_addr.
`default_nettype none
module ecid_axil
  import ecid_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXIL_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXIL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output ecid_bwr_t bus_wr,
  input wire logic wr_stall,
  input wire logic wr_err,
  output logic [AXIL_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_got_r, w_got_r, aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt, ar_fire;
  logic [AXIL_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data taken in either order
  assign bus_wr.en = aw_got_r & w_got_r & ~s_axi_bvalid & ~wr_stall;
  assign bus_wr.addr = awaddr_r;
  assign bus_wr.data = wdata_r;
  assign bus_wr.strb = wstrb_r;
  assign aw_got_nxt = (aw_got_r | (s_axi_awvalid & s_axi_awready)) & ~bus_wr.en;
  assign w_got_nxt = (w_got_r | (s_axi_wvalid & s_axi_wready)) & ~bus_wr.en;
  assign bvalid_nxt = bus_wr.en | (s_axi_bvalid & ~s_axi_bready);
  // Read path: answer one cycle after the address is taken
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign rvalid_nxt = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  // Handshake state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      s_axi_awready <= ~aw_got_nxt;
      s_axi_wready <= ~w_got_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (s_axi_awvalid && s_axi_awready)
        awaddr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (bus_wr.en)
        s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      if (ar_fire)
      begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end
endmodule
`default_nettype wire

//--- ecid_core.sv
// Decode and execute core for the file XOR and the extended instruction group.
// Assumes one instruction word per accepted instr_valid, PC in bytes,
// and an AXI4-Lite master for configuration and inspection.
`default_nettype none
module ecid_core
  import ecid_pkg::*;
#(
  parameter int STACK_DEPTH = 31
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic [PC_W-1:0] pc,
  input wire logic [AXIL_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXIL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam int MEM_DEPTH = 1 << ADDR_W;
  localparam logic [SP_W-1:0] SP_MAX = SP_W'(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

  if (STACK_DEPTH < 2 || STACK_DEPTH > 255)
  begin : g_bad_depth
    $error("STACK_DEPTH out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  ecid_state_t state_r, state_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [STAT_W-1:0] status_r, status_nxt;
  logic [PC_W-1:0] pc_nxt;
  logic [2:0][ADDR_W-1:0] ptr_r, ptr_nxt;
  logic [BANK_W-1:0] bank_r, bank_nxt;
  logic [7:0] lat_hi_r, lat_hi_nxt;
  logic [UPPER_W-1:0] lat_up_r, lat_up_nxt;
  logic ext_en_r, ext_en_nxt;
  logic [ADDR_W-1:0] maddr_r, maddr_nxt;
  logic [ADDR_W-1:0] mv_src_r, mv_src_nxt;
  logic mv_ss_r, mv_ss_nxt;
  logic [SP_W-1:0] sp_r;
  logic push, pop;
  logic [PC_W-1:0] push_val;
  logic [DATA_W-1:0] dmem [MEM_DEPTH];
  logic [PC_W-1:0] rstack [STACK_DEPTH];
  ecid_mwr_t mwr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end
  ecid_bwr_t bus_wr;
  logic fire, wr_err, rd_err;
  logic [AXIL_AW-1:0] rd_addr;
  logic [31:0] rd_data;

  ecid_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .bus_wr(bus_wr),
    .wr_stall(fire),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Known register offsets, shared by read and write decode
  function automatic logic reg_mapped(input logic [AXIL_AW-1:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_ACCUM || a == REG_BANK ||
      a == REG_PCLAT || a == REG_PC || a == REG_PTR0 || a == REG_PTR1 ||
      a == REG_PTR2 || a == REG_MADDR || a == REG_MDATA || a == REG_RSTACK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  logic ext_en, is_xor, is_add, is_sub, is_push, is_move, is_call, is_frame;
  logic dest_file, acc_sel, word2_ok;
  logic [1:0] ptr_sel;
  logic [5:0] lit6;
  logic [ADDR_W-1:0] ea, frame_ptr, ptr_sum, ptr_dif, mv_dst;
  logic [DATA_W-1:0] xor_res;
  logic [PC_W-1:0] stack_top, pc_inc, call_tgt;

  assign fire = instr_valid & instr_ready;
  assign ext_en = ext_en_r;
  assign is_xor = instr_word[15:10] == OP_XOR_FILE;
  // Extended opcodes decode only while enabled, else they fall to no-ops
  assign is_add = ext_en & ecid_op_hi(instr_word, OP_PTR_ADD);
  assign is_sub = ext_en & ecid_op_hi(instr_word, OP_PTR_SUB);
  assign is_push = ext_en & ecid_op_hi(instr_word, OP_PUSH_LIT);
  assign is_move = ext_en & ecid_op_hi(instr_word, OP_MOVE_IDX);
  assign is_call = ext_en & (instr_word == OP_CALL_ACC);
  assign dest_file = instr_word[9];
  assign acc_sel = instr_word[8];
  assign ptr_sel = instr_word[7:6];
  assign lit6 = instr_word[5:0];
  assign is_frame = ptr_sel == PTR_FRAME;
  assign frame_ptr = ptr_r[PTR_FRAME[1] ? 2 : 0];
  assign word2_ok = instr_word[15:12] == WORD2_PREFIX;

  ecid_addr u_addr (
    .file_addr(instr_word[7:0]),
    .access_sel(acc_sel),
    .bank(bank_r),
    .ext_en(ext_en),
    .frame_ptr(frame_ptr),
    .eff_addr(ea),
    .indexed()
  );

  // Datapath terms
  assign xor_res = acc_r ^ dmem[ea];
  assign ptr_sum = ADDR_W'((is_frame ? frame_ptr : ptr_r[ptr_sel]) + {6'h00, lit6});
  assign ptr_dif = ADDR_W'((is_frame ? frame_ptr : ptr_r[ptr_sel]) - {6'h00, lit6});
  assign mv_dst = mv_ss_r ? ADDR_W'(frame_ptr + {5'h00, instr_word[6:0]}) : instr_word[11:0];
  assign pc_inc = PC_W'(pc + PC_STEP);
  // Return address on top of the stack; reads as zero while the stack is empty
  assign stack_top = (sp_r == '0) ? '0 : rstack[SP_W'(sp_r - SP_ONE)];
  assign call_tgt = {lat_up_r, lat_hi_r, acc_r};

  ////////////////////////////////////////////////////////////////////////////
  // Bus register decode
  logic [31:0] wd;
  logic wr_ctrl, wr_stat, wr_acc, wr_bank, wr_lat, wr_p0, wr_p1, wr_p2;
  logic wr_maddr, wr_mdata;
  assign wd = bus_wr.data;
  assign wr_err = ~reg_mapped(bus_wr.addr);
  assign wr_ctrl = bus_wr.en && bus_wr.addr == REG_CTRL && bus_wr.strb[0];
  assign wr_stat = bus_wr.en && bus_wr.addr == REG_STATUS && bus_wr.strb[0];
  assign wr_acc = bus_wr.en && bus_wr.addr == REG_ACCUM && bus_wr.strb[0];
  assign wr_bank = bus_wr.en && bus_wr.addr == REG_BANK && bus_wr.strb[0];
  assign wr_lat = bus_wr.en && bus_wr.addr == REG_PCLAT;
  assign wr_p0 = bus_wr.en && bus_wr.addr == REG_PTR0;
  assign wr_p1 = bus_wr.en && bus_wr.addr == REG_PTR1;
  assign wr_p2 = bus_wr.en && bus_wr.addr == REG_PTR2;
  assign wr_maddr = bus_wr.en && bus_wr.addr == REG_MADDR;
  assign wr_mdata = bus_wr.en && bus_wr.addr == REG_MDATA && bus_wr.strb[0];

  // Read selection
  assign rd_err = ~reg_mapped(rd_addr);
  assign rd_data =
    (rd_addr == REG_CTRL) ? 32'(ext_en_r) :
    (rd_addr == REG_STATUS) ? 32'(status_r) :
    (rd_addr == REG_ACCUM) ? 32'(acc_r) :
    (rd_addr == REG_BANK) ? 32'(bank_r) :
    (rd_addr == REG_PCLAT) ? 32'({lat_up_r, lat_hi_r}) :
    (rd_addr == REG_PC) ? 32'(pc) :
    (rd_addr == REG_PTR0) ? 32'(ptr_r[0]) :
    (rd_addr == REG_PTR1) ? 32'(ptr_r[1]) :
    (rd_addr == REG_PTR2) ? 32'(ptr_r[2]) :
    (rd_addr == REG_MADDR) ? 32'(maddr_r) :
    (rd_addr == REG_MDATA) ? 32'(dmem[maddr_r]) :
    (rd_addr == REG_RSTACK) ? 32'(stack_top) : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic; bus writes only land in cycles with no instruction
  always_comb
  begin
    state_nxt = state_r;
    acc_nxt = wr_acc ? wd[7:0] : acc_r;
    status_nxt = wr_stat ? wd[STAT_W-1:0] : status_r;
    pc_nxt = pc;
    ptr_nxt = ptr_r;
    if (wr_p0)
      ptr_nxt[0] = wd[ADDR_W-1:0];
    if (wr_p1)
      ptr_nxt[1] = wd[ADDR_W-1:0];
    if (wr_p2)
      ptr_nxt[2] = wd[ADDR_W-1:0];
    bank_nxt = wr_bank ? wd[BANK_W-1:0] : bank_r;
    lat_hi_nxt = (wr_lat && bus_wr.strb[0]) ? wd[7:0] : lat_hi_r;
    lat_up_nxt = (wr_lat && bus_wr.strb[1]) ? wd[8 +: UPPER_W] : lat_up_r;
    ext_en_nxt = wr_ctrl ? wd[CTRL_EXT_BIT] : ext_en_r;
    maddr_nxt = wr_maddr ? wd[ADDR_W-1:0] : maddr_r;
    mv_src_nxt = mv_src_r;
    mv_ss_nxt = mv_ss_r;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_inc;
    mwr = '0;
    if (wr_mdata)
      mwr = '{en: 1'b1, addr: maddr_r, data: wd[7:0]};
    unique case (state_r)
      ST_NOP2:
        state_nxt = ST_RUN;
      ST_WORD2:
        if (fire)
        begin
          pc_nxt = pc_inc;
          state_nxt = ST_RUN;
          if (word2_ok)
            mwr = '{en: 1'b1, addr: mv_dst, data: dmem[mv_src_r]};
        end
      ST_RUN:
        if (fire)
        begin
          pc_nxt = pc_inc;
          if (is_xor)
          begin
            if (dest_file)
              mwr = '{en: 1'b1, addr: ea, data: xor_res};
            else
              acc_nxt = xor_res;
            status_nxt[STAT_Z_BIT] = xor_res == '0;
            status_nxt[STAT_N_BIT] = xor_res[DATA_W-1];
          end
          else if ((is_add || is_sub) && is_frame)
          begin
            ptr_nxt[2] = is_add ? ptr_sum : ptr_dif;
            pc_nxt = stack_top;
            pop = 1'b1;
            state_nxt = ST_NOP2;
          end
          else if (is_add || is_sub)
            ptr_nxt[ptr_sel] = is_add ? ptr_sum : ptr_dif;
          else if (is_call)
          begin
            push = 1'b1;
            pc_nxt = call_tgt;
            state_nxt = ST_NOP2;
          end
          else if (is_push)
          begin
            mwr = '{en: 1'b1, addr: frame_ptr, data: instr_word[7:0]};
            ptr_nxt[2] = ADDR_W'(frame_ptr - 1'b1);
          end
          else if (is_move)
          begin
            mv_src_nxt = ADDR_W'(frame_ptr + {5'h00, instr_word[6:0]});
            mv_ss_nxt = instr_word[7];
            state_nxt = ST_WORD2;
          end
        end
      default:
        state_nxt = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_RUN;
      instr_ready <= 1'b0;
      acc_r <= '0;
      status_r <= '0;
      pc <= '0;
      ptr_r <= '0;
      bank_r <= '0;
      lat_hi_r <= '0;
      lat_up_r <= '0;
      ext_en_r <= 1'b0;
      maddr_r <= '0;
      mv_src_r <= '0;
      mv_ss_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      instr_ready <= state_nxt != ST_NOP2;
      acc_r <= acc_nxt;
      status_r <= status_nxt;
      pc <= pc_nxt;
      ptr_r <= ptr_nxt;
      bank_r <= bank_nxt;
      lat_hi_r <= lat_hi_nxt;
      lat_up_r <= lat_up_nxt;
      ext_en_r <= ext_en_nxt;
      maddr_r <= maddr_nxt;
      mv_src_r <= mv_src_nxt;
      mv_ss_r <= mv_ss_nxt;
    end
  end

  // Return stack pointer; saturates at both ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sp_r <= '0;
    else if (push && sp_r != SP_MAX)
      sp_r <= SP_W'(sp_r + SP_ONE);
    else if (pop && sp_r != '0)
      sp_r <= SP_W'(sp_r - SP_ONE);
  end

  // Storage arrays, not reset
  always_ff @(posedge aclk)
  begin
    if (mwr.en)
      dmem[mwr.addr] <= mwr.data;
    if (push && sp_r != SP_MAX)
      rstack[sp_r] <= push_val;
  end
endmodule
`default_nettype wire

//--- ecid_properties.sv
// Port checker for the extended instruction decode core.
// Assumes it is bound onto ecid_core and sees only that module's ports.
`default_nettype none
module ecid_properties
  import ecid_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic [PC_W-1:0] pc,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXIL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Words that may hold the port for a second cycle, and unmapped reads
  wire logic two_cyc;
  wire logic rd_bad;
  assign two_cyc = instr_word == OP_CALL_ACC ||
    (instr_word[15:9] == 7'h74 && instr_word[7:6] == PTR_FRAME);
  assign rd_bad = s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > REG_RSTACK;
  // Handshake steps
  sequence s_take;
    instr_valid && instr_ready;
  endsequence
  sequence s_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_pc_step: assert property (s_take ##0 !two_cyc |=> pc == $past(pc) + PC_STEP)
    else $error("pc did not advance by one word");
  a_ready_once: assert property ($fell(instr_ready) |=> instr_ready)
    else $error("instruction port held longer than one cycle");
  a_ready_cause: assert property ($fell(instr_ready) |-> $past(instr_valid && two_cyc))
    else $error("instruction port stalled without a two-cycle word");
  a_stall_pc: assert property (!instr_ready |=> $stable(pc))
    else $error("pc moved during a no-operation cycle");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_bad: assert property (s_axi_arvalid && s_axi_arready && rd_bad
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_write_answer: assert property (s_both |-> ##[1:8] s_axi_bvalid)
    else $error("write answer late");
endmodule
bind ecid_core ecid_properties u_props (.aclk, .aresetn, .instr_valid, .instr_word,
  .instr_ready, .pc, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

//--- test_extended_cpu_instruction_decode.sv
// Self-checking bench for the extended instruction decode core.
// Assumes the core alone, driven through its instruction port and AXI4-Lite.
`default_nettype none
module test_extended_cpu_instruction_decode
  import ecid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_ready;
  logic [PC_W-1:0] pc;
  logic [AXIL_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rv;
  logic [PC_W-1:0] pce, t;
  logic [15:0] rets [2] = '{16'he8c1, 16'he9c2};
  logic [31:0] p2 [2] = '{32'h422, 32'h420};
  int n_fail = 0;
  int n_tests = 0;
  always #25 aclk = ~aclk;
  ecid_core dut (.aclk, .aresetn, .instr_valid, .instr_word, .instr_ready, .pc,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and wait limit
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo(input int i);
    if (i >= 200)
    begin
      n_fail++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bus and instruction drivers, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge aclk);
      if (aw && w && s_axi_bvalid === 1'b1)
        break;
      if (s_axi_awready === 1'b1)
      begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1)
      begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(i);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    bit ar;
    ar = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(posedge aclk);
      if (ar && s_axi_rvalid === 1'b1)
        break;
      if (s_axi_arready === 1'b1)
      begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(i);
    @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic mw(input logic [31:0] a, input logic [31:0] d);
    wr(REG_MADDR, a);
    wr(REG_MDATA, d);
  endtask
  task automatic mc(input logic [31:0] a, input logic [31:0] e);
    wr(REG_MADDR, a);
    rc(REG_MDATA, e);
  endtask
  task automatic ins(input logic [15:0] w);
    int i;
    instr_valid <= 1'b1;
    instr_word <= w;
    for (i = 0; i < 200; i++)
    begin
      @(posedge aclk);
      if (instr_ready === 1'b1)
        break;
    end
    tmo(i);
    pce = pce + PC_STEP;
  endtask
  task automatic idle();
    instr_valid <= 1'b0;
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    pce = '0;
    rc(REG_CTRL, 32'h0);
    rd(8'h40);
    chk(32'(rs), 32'(RESP_SLVERR));
    wr(8'h44, 32'h1);
    chk(32'(rs), 32'(RESP_SLVERR));
    $display("test reset done");
    wr(REG_STATUS, 32'h0b);
    wr(REG_ACCUM, 32'h55);
    mw(32'h5, 32'haf);
    ins(16'h1a05);
    idle();
    mc(32'h5, 32'hfa);
    rc(REG_ACCUM, 32'h55);
    rc(REG_STATUS, 32'h1b);
    wr(REG_BANK, 32'h2);
    mw(32'h260, 32'h55);
    ins(16'h1960);
    idle();
    rc(REG_ACCUM, 32'h0);
    rc(REG_STATUS, 32'h0f);
    mc(32'h260, 32'h55);
    $display("test xor done");
    wr(REG_PTR2, 32'h3ff);
    ins(16'he8a3);
    ins(OP_CALL_ACC);
    idle();
    chk(32'(instr_ready), 32'h1);
    rc(REG_PTR2, 32'h3ff);
    rc(REG_PC, 32'(pce));
    $display("test disabled done");
    wr(REG_CTRL, 32'h1);
    wr(REG_PTR1, 32'h100);
    ins(16'he8a3);
    ins(16'he945);
    idle();
    rc(REG_PTR2, 32'h422);
    rc(REG_PTR1, 32'hfb);
    rc(REG_STATUS, 32'h0f);
    wr(REG_ACCUM, 32'h0f);
    mw(32'h427, 32'hf0);
    ins(16'h1a05);
    idle();
    mc(32'h427, 32'hff);
    mc(32'h5, 32'hfa);
    ins(16'hea5a);
    idle();
    mc(32'h422, 32'h5a);
    rc(REG_PTR2, 32'h421);
    ins(16'heb06);
    ins(16'hf123);
    ins(16'heb86);
    ins(16'hf002);
    idle();
    mc(32'h123, 32'hff);
    mc(32'h423, 32'hff);
    rc(REG_PC, 32'(pce));
    $display("test extended done");
    wr(REG_PCLAT, 32'h10);
    wr(REG_ACCUM, 32'h06);
    for (int j = 0; j < 2; j++)
    begin
      t = pce + PC_STEP;
      ins(OP_CALL_ACC);
      idle();
      chk(32'(instr_ready), 32'h0);
      rc(REG_PC, 32'h1006);
      rc(REG_RSTACK, 32'(t));
      ins(rets[j]);
      idle();
      chk(32'(instr_ready), 32'h0);
      rc(REG_PC, 32'(t));
      rc(REG_PTR2, p2[j]);
      pce = t;
    end
    rc(REG_STATUS, 32'h1b);
    $display("test call done");
    give_verdict();
  end
endmodule
`default_nettype wire
